// [hw/dfs_params.svh]
// offsets, field positions and reset values of the format sequencer word block
`ifndef DFS_PARAMS_SVH
`define DFS_PARAMS_SVH

`define DFS_ADDR_W 8
`define DFS_BYTE_W 8

// current sequencer word
`define DFS_REG_CUR_NEXT 8'h49
`define DFS_REG_CUR_COUNT 8'h4A
`define DFS_REG_CUR_CTRL 8'h4B
`define DFS_REG_CUR_DATA 8'h4C

// mode and status registers
`define DFS_REG_SECTOR_MODE 8'h77
`define DFS_REG_STATUS 8'h79
`define DFS_REG_WRITE_SRC 8'h7A
`define DFS_REG_MARK_CFG 8'h7B

// control store field arrays
`define DFS_STORE_NEXT_BASE 8'h80
`define DFS_STORE_CTRL_BASE 8'hA0
`define DFS_STORE_COUNT_BASE 8'hC0
`define DFS_STORE_DATA_BASE 8'hE0
`define DFS_STORE_WORDS 31
`define DFS_STORE_AW 5

// control field bits
`define DFS_CTRL_MOVE 0
`define DFS_CTRL_RGATE 6
`define DFS_CTRL_WGATE 7

// count field bits
`define DFS_CNT_SEL 4
`define DFS_CNT_SWITCH 5
`define DFS_CNT_CHECK 6
`define DFS_CNT_MARK 7
`define DFS_CNT_MASK4 8'h0F
`define DFS_CNT_MASK5 8'h1F

// register bits
`define DFS_HARD_SECTOR_BIT 7
`define DFS_SEEN_BIT 7
`define DFS_HOLD_BIT 5
`define DFS_MARK_LEN_W 4

`define DFS_BYTE_ZERO 8'h00
`define DFS_BIT_LAST 3'h7
`define DFS_FIFO_DEPTH 2

`endif

// [hw/dfs_pkg.sv]
// types shared by the format sequencer word block
package dfs_pkg;

  typedef enum logic [1:0] {
    DFS_IDLE = 2'b00,
    DFS_ENTER = 2'b01,
    DFS_EXEC = 2'b10
  } dfs_state_t;

endpackage : dfs_pkg

// [hw/dfs_word.sv]
// format sequencer word decode, control store access and NRZ byte path
//
// Contract
// - On entering a state, load the byte counter from count bits 3-0.
// - Counter at zero fetches the next word from the control store.
// - Count bit 4 counts when both gates clear or payload-move set.
// - Gate open without move: bit 4 set picks CRC, clear picks 56-bit code.
// - Bit 5 counts with move; otherwise it hands buffer clock to disk.
// - Buffer clock returns to system clock when the check field ends.
// - Bit 6, no move, gate open: marks the NRZ bytes as a check field.
// - Bit 7, no move, read gate: set the mark seen flag.
// - Bit 7, no move, write gate: set mark seen and initialise check logic.
// - Soft sector mode drives the mark write strobe as configured.
// - Data field feeds overhead write bytes and is the read compare operand.
// - Move with write gate and hold source bit clear takes write bytes from buffer memory.
// - Hold source bit with write gate takes write bytes from data field.
// - Word registers readable always; writable only while stopped.
// - Microcontroller reaches next, count, control and data of current word.
`timescale 1ns/10ps
`include "dfs_params.svh"

module dfs_word #(
  parameter int WORDS = `DFS_STORE_WORDS,
  parameter int DEPTH = `DFS_FIFO_DEPTH
) (
  input wire logic REF_CLK,
  input wire logic RESETN,
  input wire logic LINK_CLK,
  input wire logic [7:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  input wire logic SEQ_RUN,
  input wire logic [7:0] MEM_DATA,
  input wire logic MEM_VALID,
  output logic MEM_READY,
  input wire logic NRZ_IN,
  output logic NRZ_OUT,
  output logic MARK_WRITE_N,
  output logic READ_GATE,
  output logic WRITE_GATE,
  output logic POLY_CRC,
  output logic CHECK_INIT,
  output logic CHECK_FIELD,
  output logic BUF_CLK_DISK,
  output logic CMP_MATCH
);
  import dfs_pkg::*;

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int FW = `DFS_BYTE_W + 1 + `DFS_MARK_LEN_W;

  function automatic logic [7:0] count_load(input logic [7:0] cnt, input logic [7:0] ctrl);
    logic [7:0] val;
    val = cnt & `DFS_CNT_MASK4;
    if (ctrl[`DFS_CTRL_MOVE])
      val = cnt;
    else if (!ctrl[`DFS_CTRL_RGATE] && !ctrl[`DFS_CTRL_WGATE])
      val = cnt & `DFS_CNT_MASK5;
    return val;
  endfunction : count_load

  function automatic logic in_store(input logic [7:0] addr, input logic [7:0] base);
    return (addr >= base) && ({1'b0, addr} < ({1'b0, base} + 9'(WORDS)));
  endfunction : in_store

  function automatic logic [`DFS_STORE_AW-1:0] store_idx(input logic [7:0] addr,
                                                         input logic [7:0] base);
    logic [7:0] diff;
    diff = addr - base;
    return diff[`DFS_STORE_AW-1:0];
  endfunction : store_idx

  // control store
  logic [7:0] store_next [WORDS];
  logic [7:0] store_ctrl [WORDS];
  logic [7:0] store_count [WORDS];
  logic [7:0] store_data [WORDS];

  dfs_state_t state;
  dfs_state_t next_state;
  logic [7:0] cur_next;
  logic [7:0] cur_count;
  logic [7:0] cur_ctrl;
  logic [7:0] cur_data;
  logic [7:0] byte_cnt;
  logic [7:0] sector_mode;
  logic [7:0] write_src;
  logic [7:0] mark_cfg;
  logic mark_seen;
  logic running;
  logic entering;
  logic fetch;
  logic move;
  logic rgate;
  logic wgate;
  logic field_cmd;
  logic soft_sector;
  logic hold_src;
  logic stopped;
  logic [`DFS_STORE_AW-1:0] fetch_idx;

  // byte time crossing from the link
  logic byte_tgl;
  logic tick_s1;
  logic tick_s2;
  logic tick_s3;
  logic tick;
  logic [7:0] rx_hold;

  // write byte path
  logic owed;
  logic first_byte;
  logic push;
  logic src_valid;
  logic [7:0] src_byte;
  logic push_mark;
  logic [FW-1:0] fifo_mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] fifo_cnt;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic xfer_req;
  logic [FW-1:0] xfer_word;
  logic ack_s1;
  logic ack_s2;
  logic xfer_busy;
  logic check_prev;

  // link side
  logic lrst_s1;
  logic lrst_n;
  logic [2:0] bit_cnt;
  logic [7:0] rx_shift;
  logic [7:0] tx_shift;
  logic req_s1;
  logic req_s2;
  logic link_ack;
  logic [`DFS_MARK_LEN_W-1:0] mark_cnt;

  assign move = cur_ctrl[`DFS_CTRL_MOVE];
  assign rgate = cur_ctrl[`DFS_CTRL_RGATE];
  assign wgate = cur_ctrl[`DFS_CTRL_WGATE];
  // illegal move-with-gate words are not policed; move simply wins
  assign field_cmd = !move && (rgate || wgate);
  assign running = (state != DFS_IDLE);
  assign stopped = (state == DFS_IDLE);
  assign entering = (state == DFS_ENTER);
  assign fetch = (state == DFS_EXEC) && SEQ_RUN && tick && (byte_cnt == `DFS_BYTE_ZERO);
  assign fetch_idx = cur_next[`DFS_STORE_AW-1:0];
  assign soft_sector = !sector_mode[`DFS_HARD_SECTOR_BIT];
  assign hold_src = write_src[`DFS_HOLD_BIT];

  always_comb
  begin
    next_state = state;
    unique case (state)
      DFS_IDLE:
      begin
        if (SEQ_RUN)
          next_state = DFS_ENTER;
      end
      DFS_ENTER:
      begin
        next_state = SEQ_RUN ? DFS_EXEC : DFS_IDLE;
      end
      DFS_EXEC:
      begin
        if (!SEQ_RUN)
          next_state = DFS_IDLE;
        else if (fetch)
          next_state = DFS_ENTER;
      end
      default:
      begin
        next_state = DFS_IDLE;
      end
    endcase
  end

  always_ff @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
      state <= DFS_IDLE;
    else
      state <= next_state;
  end

  // store writes are always accepted; the sequencer only reads the store
  always_ff @(posedge REF_CLK)
  begin
    if (REG_WR && in_store(REG_ADDR, `DFS_STORE_NEXT_BASE))
      store_next[store_idx(REG_ADDR, `DFS_STORE_NEXT_BASE)] <= REG_WDATA;
    if (REG_WR && in_store(REG_ADDR, `DFS_STORE_CTRL_BASE))
      store_ctrl[store_idx(REG_ADDR, `DFS_STORE_CTRL_BASE)] <= REG_WDATA;
    if (REG_WR && in_store(REG_ADDR, `DFS_STORE_COUNT_BASE))
      store_count[store_idx(REG_ADDR, `DFS_STORE_COUNT_BASE)] <= REG_WDATA;
    if (REG_WR && in_store(REG_ADDR, `DFS_STORE_DATA_BASE))
      store_data[store_idx(REG_ADDR, `DFS_STORE_DATA_BASE)] <= REG_WDATA;
  end

  // current word: fetched by the sequencer, written by software only when stopped
  always_ff @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      cur_next <= `DFS_BYTE_ZERO;
      cur_count <= `DFS_BYTE_ZERO;
      cur_ctrl <= `DFS_BYTE_ZERO;
      cur_data <= `DFS_BYTE_ZERO;
    end
    else if (fetch)
    begin
      cur_next <= store_next[fetch_idx];
      cur_count <= store_count[fetch_idx];
      cur_ctrl <= store_ctrl[fetch_idx];
      cur_data <= store_data[fetch_idx];
    end
    else if (REG_WR && stopped)
    begin
      if (REG_ADDR == `DFS_REG_CUR_NEXT)
        cur_next <= REG_WDATA;
      if (REG_ADDR == `DFS_REG_CUR_COUNT)
        cur_count <= REG_WDATA;
      if (REG_ADDR == `DFS_REG_CUR_CTRL)
        cur_ctrl <= REG_WDATA;
      if (REG_ADDR == `DFS_REG_CUR_DATA)
        cur_data <= REG_WDATA;
    end
  end

  always_ff @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      sector_mode <= `DFS_BYTE_ZERO;
      write_src <= `DFS_BYTE_ZERO;
      mark_cfg <= `DFS_BYTE_ZERO;
    end
    else if (REG_WR)
    begin
      if (REG_ADDR == `DFS_REG_SECTOR_MODE)
        sector_mode <= REG_WDATA;
      if (REG_ADDR == `DFS_REG_WRITE_SRC)
        write_src <= REG_WDATA;
      if (REG_ADDR == `DFS_REG_MARK_CFG)
        mark_cfg <= REG_WDATA;
    end
  end

  always_ff @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
      REG_RDATA <= `DFS_BYTE_ZERO;
    else if (REG_RD)
    begin
      REG_RDATA <= `DFS_BYTE_ZERO;
      if (REG_ADDR == `DFS_REG_CUR_NEXT)
        REG_RDATA <= cur_next;
      if (REG_ADDR == `DFS_REG_CUR_COUNT)
        REG_RDATA <= cur_count;
      if (REG_ADDR == `DFS_REG_CUR_CTRL)
        REG_RDATA <= cur_ctrl;
      if (REG_ADDR == `DFS_REG_CUR_DATA)
        REG_RDATA <= cur_data;
      if (REG_ADDR == `DFS_REG_SECTOR_MODE)
        REG_RDATA <= sector_mode;
      if (REG_ADDR == `DFS_REG_STATUS)
        REG_RDATA[`DFS_SEEN_BIT] <= mark_seen;
      if (REG_ADDR == `DFS_REG_WRITE_SRC)
        REG_RDATA <= write_src;
      if (REG_ADDR == `DFS_REG_MARK_CFG)
        REG_RDATA <= mark_cfg;
      if (in_store(REG_ADDR, `DFS_STORE_NEXT_BASE))
        REG_RDATA <= store_next[store_idx(REG_ADDR, `DFS_STORE_NEXT_BASE)];
      if (in_store(REG_ADDR, `DFS_STORE_CTRL_BASE))
        REG_RDATA <= store_ctrl[store_idx(REG_ADDR, `DFS_STORE_CTRL_BASE)];
      if (in_store(REG_ADDR, `DFS_STORE_COUNT_BASE))
        REG_RDATA <= store_count[store_idx(REG_ADDR, `DFS_STORE_COUNT_BASE)];
      if (in_store(REG_ADDR, `DFS_STORE_DATA_BASE))
        REG_RDATA <= store_data[store_idx(REG_ADDR, `DFS_STORE_DATA_BASE)];
    end
  end

  // byte counter
  always_ff @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
      byte_cnt <= `DFS_BYTE_ZERO;
    else if (entering)
      byte_cnt <= count_load(cur_count, cur_ctrl);
    else if ((state == DFS_EXEC) && tick && (byte_cnt != `DFS_BYTE_ZERO))
      byte_cnt <= byte_cnt - 8'h01;
  end

  // byte boundaries from the link clock; first stage feeds only the second
  always_ff @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      tick_s1 <= 1'b0;
      tick_s2 <= 1'b0;
      tick_s3 <= 1'b0;
    end
    else
    begin
      tick_s1 <= byte_tgl;
      tick_s2 <= tick_s1;
      tick_s3 <= tick_s2;
    end
  end
  assign tick = tick_s2 ^ tick_s3;

  always_ff @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      READ_GATE <= 1'b0;
      WRITE_GATE <= 1'b0;
      CHECK_FIELD <= 1'b0;
      check_prev <= 1'b0;
    end
    else
    begin
      // a move word keeps whatever gate the word before it opened
      READ_GATE <= running && (move ? READ_GATE : rgate);
      WRITE_GATE <= running && (move ? WRITE_GATE : wgate);
      CHECK_FIELD <= running && field_cmd && cur_count[`DFS_CNT_CHECK];
      check_prev <= CHECK_FIELD;
    end
  end

  always_ff @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      POLY_CRC <= 1'b0;
      CHECK_INIT <= 1'b0;
    end
    else
    begin
      if (entering && field_cmd)
        POLY_CRC <= cur_count[`DFS_CNT_SEL];
      CHECK_INIT <= entering && field_cmd;
    end
  end

  // handover set wins over the end-of-check release in the same cycle
  always_ff @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
      BUF_CLK_DISK <= 1'b0;
    else if (entering && !move && cur_count[`DFS_CNT_SWITCH])
      BUF_CLK_DISK <= 1'b1;
    else if (check_prev && !CHECK_FIELD)
      BUF_CLK_DISK <= 1'b0;
  end

  // mark seen: set wins over a software clear by writing one
  always_ff @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
      mark_seen <= 1'b0;
    else if (entering && field_cmd && cur_count[`DFS_CNT_MARK])
      mark_seen <= 1'b1;
    else if (REG_WR && (REG_ADDR == `DFS_REG_STATUS) && REG_WDATA[`DFS_SEEN_BIT])
      mark_seen <= 1'b0;
  end

  // rx_hold is stable for a whole byte time once the tick arrives
  always_ff @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
      CMP_MATCH <= 1'b0;
    else if (tick && READ_GATE)
      CMP_MATCH <= (rx_hold == cur_data);
  end

  // write source selection; hold overrides move
  always_comb
  begin
    src_byte = cur_data;
    src_valid = 1'b1;
    if (move && !hold_src)
    begin
      src_byte = MEM_DATA;
      src_valid = MEM_VALID;
    end
    else if (hold_src)
    begin
      src_byte = cur_data;
      src_valid = 1'b1;
    end
  end

  assign push = owed && fifo_in_ready && src_valid;
  assign MEM_READY = owed && fifo_in_ready && move && !hold_src && WRITE_GATE;
  assign push_mark = first_byte && field_cmd && wgate && cur_count[`DFS_CNT_MARK] && soft_sector;

  // a byte owed stays owed until the buffer accepts it; new owing wins
  always_ff @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      owed <= 1'b0;
      first_byte <= 1'b0;
    end
    else
    begin
      owed <= (owed && !push) || (tick && running && WRITE_GATE);
      if (entering)
        first_byte <= 1'b1;
      else if (push)
        first_byte <= 1'b0;
    end
  end

  // two-entry buffer
  assign fifo_in_ready = (fifo_cnt < (AW+1)'(DEPTH));
  assign fifo_out_valid = (fifo_cnt != '0);
  assign xfer_busy = (xfer_req != ack_s2);
  assign fifo_out_ready = !xfer_busy;

  always_ff @(posedge REF_CLK)
  begin
    if (push)
      fifo_mem[wr_ptr] <= {push_mark, mark_cfg[`DFS_MARK_LEN_W-1:0], src_byte};
  end

  always_ff @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fifo_cnt <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + AW'(1);
      if (fifo_out_valid && fifo_out_ready)
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + AW'(1);
      fifo_cnt <= fifo_cnt + (AW+1)'(push) - (AW+1)'(fifo_out_valid && fifo_out_ready);
    end
  end

  // toggle handshake carries one byte word to the link
  always_ff @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      xfer_req <= 1'b0;
      xfer_word <= '0;
      ack_s1 <= 1'b0;
      ack_s2 <= 1'b0;
    end
    else
    begin
      ack_s1 <= link_ack;
      ack_s2 <= ack_s1;
      if (fifo_out_valid && fifo_out_ready)
      begin
        xfer_word <= fifo_mem[rd_ptr];
        xfer_req <= !xfer_req;
      end
    end
  end

  // link clock domain
  always_ff @(posedge LINK_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      lrst_s1 <= 1'b0;
      lrst_n <= 1'b0;
    end
    else
    begin
      lrst_s1 <= 1'b1;
      lrst_n <= lrst_s1;
    end
  end

  always_ff @(posedge LINK_CLK or negedge lrst_n)
  begin
    if (!lrst_n)
    begin
      bit_cnt <= 3'h0;
      byte_tgl <= 1'b0;
      rx_shift <= `DFS_BYTE_ZERO;
      rx_hold <= `DFS_BYTE_ZERO;
    end
    else
    begin
      bit_cnt <= bit_cnt + 3'h1;
      rx_shift <= {rx_shift[6:0], NRZ_IN};
      if (bit_cnt == `DFS_BIT_LAST)
      begin
        byte_tgl <= !byte_tgl;
        rx_hold <= {rx_shift[6:0], NRZ_IN};
      end
    end
  end

  always_ff @(posedge LINK_CLK or negedge lrst_n)
  begin
    if (!lrst_n)
    begin
      req_s1 <= 1'b0;
      req_s2 <= 1'b0;
      link_ack <= 1'b0;
      tx_shift <= `DFS_BYTE_ZERO;
      mark_cnt <= '0;
      NRZ_OUT <= 1'b0;
      MARK_WRITE_N <= 1'b1;
    end
    else
    begin
      req_s1 <= xfer_req;
      req_s2 <= req_s1;
      NRZ_OUT <= tx_shift[7];
      MARK_WRITE_N <= (mark_cnt == '0);
      if (mark_cnt != '0)
        mark_cnt <= mark_cnt - 1'b1;
      if (bit_cnt == `DFS_BIT_LAST)
      begin
        tx_shift <= `DFS_BYTE_ZERO;
        if (req_s2 != link_ack)
        begin
          link_ack <= req_s2;
          tx_shift <= xfer_word[`DFS_BYTE_W-1:0];
          if (xfer_word[FW-1])
            mark_cnt <= xfer_word[FW-2:`DFS_BYTE_W];
        end
      end
      else
        tx_shift <= {tx_shift[6:0], 1'b0};
    end
  end

endmodule : dfs_word

// [verification/dfs_word_monitor.sv]
// concurrent checks on the ports of the sequencer word block
`timescale 1ns/10ps
module dfs_word_monitor (
  input wire logic REF_CLK,
  input wire logic RESETN,
  input wire logic [7:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_WDATA,
  input wire logic [7:0] REG_RDATA,
  input wire logic SEQ_RUN,
  input wire logic READ_GATE,
  input wire logic WRITE_GATE,
  input wire logic POLY_CRC,
  input wire logic CHECK_INIT,
  input wire logic CHECK_FIELD,
  input wire logic BUF_CLK_DISK
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RESETN);
  // three cycles low lets the state machine settle to idle
  sequence s_stopped;
    !SEQ_RUN [*3];
  endsequence
  sequence s_count_wr;
    REG_WR && !REG_RD && REG_ADDR == 8'h4A;
  endsequence
  sequence s_count_rd;
    REG_RD && !REG_WR && REG_ADDR == 8'h4A;
  endsequence
  property p_park_rw;
    (s_stopped ##0 s_count_wr) ##1 s_count_rd |=> REG_RDATA == $past(REG_WDATA, 2);
  endproperty
  property p_hold;
    !REG_RD |=> $stable(REG_RDATA);
  endproperty
  property p_unmapped;
    REG_RD && REG_ADDR == 8'h00 |=> REG_RDATA == 8'h00;
  endproperty
  property p_init_pulse;
    CHECK_INIT |=> !CHECK_INIT;
  endproperty
  property p_init_gate;
    CHECK_INIT |-> ##[0:2] (READ_GATE || WRITE_GATE);
  endproperty
  property p_poly;
    $changed(POLY_CRC) |-> CHECK_INIT || $past(CHECK_INIT) || $past(CHECK_INIT, 2);
  endproperty
  property p_field;
    CHECK_FIELD |-> READ_GATE || WRITE_GATE || $past(READ_GATE || WRITE_GATE);
  endproperty
  property p_stop;
    s_stopped |-> !READ_GATE && !WRITE_GATE && !CHECK_FIELD;
  endproperty
  property p_switch;
    $rose(BUF_CLK_DISK) |-> $past(SEQ_RUN, 2);
  endproperty
  a_park_rw: assert property (p_park_rw) else $error("count field readback wrong");
  a_hold: assert property (p_hold) else $error("read data moved without read");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_init_pulse: assert property (p_init_pulse) else $error("check init too long");
  a_init_gate: assert property (p_init_gate) else $error("check init without gate");
  a_poly: assert property (p_poly) else $error("polynomial moved off entry");
  a_field: assert property (p_field) else $error("check field without gate");
  a_stop: assert property (p_stop) else $error("gates open while stopped");
  a_switch: assert property (p_switch) else $error("clock handover while stopped");
endmodule : dfs_word_monitor

bind dfs_word dfs_word_monitor dfs_word_monitor_i (
  .REF_CLK(REF_CLK), .RESETN(RESETN), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR),
  .REG_RD(REG_RD), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .SEQ_RUN(SEQ_RUN),
  .READ_GATE(READ_GATE), .WRITE_GATE(WRITE_GATE), .POLY_CRC(POLY_CRC),
  .CHECK_INIT(CHECK_INIT), .CHECK_FIELD(CHECK_FIELD), .BUF_CLK_DISK(BUF_CLK_DISK)
);

// [verification/dfs_disk_model.sv]
// disk read/write channel: reference clock, read bits, write capture
`timescale 1ns/10ps
module dfs_disk_model (
  output logic link_clk,
  output logic nrz_in,
  input wire logic nrz_out,
  input wire logic read_gate,
  input wire logic [7:0] send_byte,
  output logic [7:0] last_written
);
  logic [2:0] bit_idx;
  // reference clock runs free, so link reset always sees edges
  initial
  begin
    link_clk = 1'b0;
    nrz_in = 1'b0;
    // frame lines up with the block's link reset release in this bench
    bit_idx = 3'h1;
    last_written = 8'h00;
    #0.3;
    forever #6 link_clk = ~link_clk;
  end
  always @(posedge link_clk)
  begin
    last_written <= {last_written[6:0], nrz_out};
    #1;
    if (read_gate)
      nrz_in = send_byte[bit_idx];
    else
      nrz_in = ~nrz_in; // undriven line must not look settled
    bit_idx = bit_idx - 3'h1;
  end
endmodule : dfs_disk_model

// [verification/test_dfs_word.sv]
// self-checking bench for the format sequencer word block
`timescale 1ns/10ps
module test_dfs_word;
  logic REF_CLK = 1'b0;
  logic RESETN = 1'b0;
  logic LINK_CLK;
  logic [7:0] REG_ADDR = 8'h00;
  logic REG_WR = 1'b0;
  logic REG_RD = 1'b0;
  logic [7:0] REG_WDATA = 8'h00;
  logic [7:0] REG_RDATA;
  logic SEQ_RUN = 1'b0;
  logic [7:0] MEM_DATA = 8'hFF;
  logic MEM_VALID = 1'b0;
  logic MEM_READY, NRZ_IN, NRZ_OUT, MARK_WRITE_N, READ_GATE, WRITE_GATE;
  logic POLY_CRC, CHECK_INIT, CHECK_FIELD, BUF_CLK_DISK, CMP_MATCH;
  logic [7:0] send_byte = 8'hFF;
  logic [7:0] wr_seen;
  logic [7:0] rv;
  logic saw_init, saw_mark, saw_full;
  int taken;
  int bad_count = 0;
  int checked = 0;
  always #2 REF_CLK = ~REF_CLK;
  dfs_word dfs_word_i (
    .REF_CLK(REF_CLK), .RESETN(RESETN), .LINK_CLK(LINK_CLK), .REG_ADDR(REG_ADDR),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
    .SEQ_RUN(SEQ_RUN), .MEM_DATA(MEM_DATA), .MEM_VALID(MEM_VALID), .MEM_READY(MEM_READY),
    .NRZ_IN(NRZ_IN), .NRZ_OUT(NRZ_OUT), .MARK_WRITE_N(MARK_WRITE_N),
    .READ_GATE(READ_GATE), .WRITE_GATE(WRITE_GATE), .POLY_CRC(POLY_CRC),
    .CHECK_INIT(CHECK_INIT), .CHECK_FIELD(CHECK_FIELD), .BUF_CLK_DISK(BUF_CLK_DISK),
    .CMP_MATCH(CMP_MATCH)
  );
  dfs_disk_model dfs_disk_model_i (
    .link_clk(LINK_CLK), .nrz_in(NRZ_IN), .nrz_out(NRZ_OUT), .read_gate(READ_GATE),
    .send_byte(send_byte), .last_written(wr_seen)
  );
  always @(posedge REF_CLK)
  begin
    if (CHECK_INIT === 1'b1) saw_init <= 1'b1;
    if (MARK_WRITE_N === 1'b0) saw_mark <= 1'b1;
    if (MEM_VALID && MEM_READY === 1'b0) saw_full <= 1'b1;
    if (MEM_VALID && MEM_READY === 1'b1) taken <= taken + 1;
  end
  task report_and_stop;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : report_and_stop
  task chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  // bus tasks start just after an edge; the strobe stays up until the next call or wait
  task wr(input logic [7:0] a, input logic [7:0] d);
    REG_ADDR = a;
    REG_WDATA = d;
    REG_RD = 1'b0;
    REG_WR = 1'b1;
    @(posedge REF_CLK);
    #1;
  endtask : wr
  task rd(input logic [7:0] a, output logic [7:0] d);
    REG_ADDR = a;
    REG_WR = 1'b0;
    REG_RD = 1'b1;
    @(posedge REF_CLK);
    #1;
    d = REG_RDATA;
  endtask : rd
  task wt(input int n);
    REG_WR = 1'b0;
    REG_RD = 1'b0;
    repeat (n) @(posedge REF_CLK);
    #1;
  endtask : wt
  task ld(input logic [7:0] n, input logic [7:0] c, input logic [7:0] k, input logic [7:0] d);
    wr(8'h49, n);
    wr(8'h4A, c);
    wr(8'h4B, k);
    wr(8'h4C, d);
  endtask : ld
  task st(input logic [4:0] i, input logic [7:0] n, input logic [7:0] c,
          input logic [7:0] k, input logic [7:0] d);
    wr({3'h4, i}, n);
    wr({3'h6, i}, c);
    wr({3'h5, i}, k);
    wr({3'h7, i}, d);
  endtask : st
  task t_regs;
    for (int i = 0; i < 4; i++)
      wr(8'(8'h49 + i), 8'(8'hA0 + i));
    for (int i = 0; i < 4; i++)
    begin
      rd(8'(8'h49 + i), rv);
      chk("word field", rv, 8'(8'hA0 + i));
    end
    wr(8'h4A, 8'h3C);
    rd(8'h4A, rv);
    chk("count field", rv, 8'h3C);
    rd(8'h00, rv);
    chk("unmapped", rv, 8'h00);
    $display("test regs done");
  endtask : t_regs
  task t_count;
    ld(8'h03, 8'h13, 8'h00, 8'h11);
    st(5'h03, 8'h03, 8'h00, 8'h00, 8'h22);
    SEQ_RUN = 1'b1;
    wt(300);
    rd(8'h4C, rv);
    chk("five bit count", rv, 8'h11);
    wt(250);
    rd(8'h4C, rv);
    chk("next word", rv, 8'h22);
    wr(8'h4C, 8'h55);
    rd(8'h4C, rv);
    chk("write while running", rv, 8'h22);
    SEQ_RUN = 1'b0;
    wt(5);
    $display("test count done");
  endtask : t_count
  task t_write;
    wr(8'h77, 8'h00);
    wr(8'h7B, 8'h04);
    wr(8'h79, 8'h80);
    ld(8'h01, 8'hB3, 8'h80, 8'hFF);
    st(5'h01, 8'h01, 8'h5F, 8'h80, 8'hFF);
    saw_init = 1'b0;
    saw_mark = 1'b0;
    SEQ_RUN = 1'b1;
    wt(190);
    chk("crc select", {7'h00, POLY_CRC}, 8'h01);
    chk("check init", {7'h00, saw_init}, 8'h01);
    chk("mark strobe", {7'h00, saw_mark}, 8'h01);
    chk("check field", {7'h00, CHECK_FIELD}, 8'h01);
    chk("overhead bytes", wr_seen, 8'hFF);
    chk("disk clock on", {7'h00, BUF_CLK_DISK}, 8'h01);
    rd(8'h4A, rv);
    chk("loaded count", rv, 8'h5F);
    rd(8'h79, rv);
    chk("mark seen write", rv & 8'h80, 8'h80);
    SEQ_RUN = 1'b0;
    wt(5);
    chk("clock back", {7'h00, BUF_CLK_DISK}, 8'h00);
    $display("test write done");
  endtask : t_write
  task t_read;
    wr(8'h79, 8'h80);
    ld(8'h02, 8'hA1, 8'h40, 8'h96);
    st(5'h02, 8'h02, 8'hA1, 8'h40, 8'h96);
    send_byte = 8'h96;
    SEQ_RUN = 1'b1;
    wt(150);
    chk("long code select", {7'h00, POLY_CRC}, 8'h00);
    chk("disk clock", {7'h00, BUF_CLK_DISK}, 8'h01);
    chk("compare", {7'h00, CMP_MATCH}, 8'h01);
    rd(8'h79, rv);
    chk("mark seen read", rv & 8'h80, 8'h80);
    SEQ_RUN = 1'b0;
    wt(5);
    $display("test read done");
  endtask : t_read
  task t_buf;
    // write gate word opens the gate, then a move word streams buffer bytes
    ld(8'h04, 8'h03, 8'h80, 8'h00);
    st(5'h04, 8'h04, 8'h07, 8'h01, 8'h00);
    taken = 0;
    saw_full = 1'b0;
    MEM_VALID = 1'b1;
    SEQ_RUN = 1'b1;
    wt(300);
    chk("bytes taken", {7'h00, taken > 2 && taken <= 13}, 8'h01);
    chk("buffer refuses", {7'h00, saw_full}, 8'h01);
    chk("memory bytes", wr_seen, 8'hFF);
    wr(8'h7A, 8'h20);
    wt(200);
    rv = 8'(taken);
    chk("held source", wr_seen, 8'h00);
    wt(50);
    chk("memory idle", 8'(taken), rv);
    MEM_VALID = 1'b0;
    SEQ_RUN = 1'b0;
    wt(5);
    $display("test buffer done");
  endtask : t_buf
  initial
  begin
    repeat (3) @(posedge REF_CLK);
    #1 RESETN = 1'b1;
    t_regs;
    t_count;
    t_write;
    t_read;
    t_buf;
    report_and_stop;
  end
  initial
  begin
    repeat (4000) @(posedge REF_CLK);
    bad_count++;
    report_and_stop;
  end
endmodule : test_dfs_word
